/* dual_timer_regs.svh */
// register map, field positions, codes and reset values of the dual 8-bit timer
// How it works
// - event mode counts every valid input edge
// - clock code picks rising or falling edge
// - match clears counter, pulses channel interrupt
// - output pin toggles on each match when output and invert are enabled
// - codes 0110-1111 pick prescaled periods
// - level bits preset each channel's output
// - cascade bit joins counters into sixteen bits
// - low uses low code, high counts overflow
// - count enable bit gates cascaded counting
// - sixteen-bit match clears both, pulses channel two
// - interval is compare plus one ticks
// - low match still pulses and toggles channel one
// - sixteen-bit count read in one access
// - cascade codes 0000/0001 count channel one edges
// - level field: keep, low, high, prohibited
// - level bits always read back zero
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH

`define ADDR_LOW_COMPARE        3'h0
`define ADDR_HIGH_COMPARE       3'h1
`define ADDR_COUNT_CLOCK_SELECT 3'h2
`define ADDR_OUTPUT_CONTROL     3'h3
`define ADDR_TIMER_MODE_CONTROL 3'h4
`define ADDR_COUNT_WORD         3'h5

`define OC_OUTPUT_ENABLE 0
`define OC_INVERT_ENABLE 1
`define OC_LEVEL_RESET   2
`define OC_LEVEL_SET     3
`define OC_STRIDE        4

`define TMC_COUNT_ENABLE   0
`define TMC_CH2_ENABLE     1
`define TMC_CASCADE_SELECT 2

`define CODE_EDGE_FALL      4'h0
`define CODE_EDGE_RISE      4'h1
`define CODE_PRESCALE_FIRST 4'h6
`define CODE_PRESCALE_TOP   4'hf
`define PRESCALE_EXP_OFFSET 4'h4
`define PRESCALE_EXP_TOP    4'hc
`define DIV_WIDTH           12

`define RESET_BYTE 8'h00
`define COUNT_MAX  8'hff

`endif

/* dual_timer_pkg.sv */
// types shared by the dual 8-bit timer
package dual_timer_pkg;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_EDGE_RISE,
		SRC_EDGE_FALL,
		SRC_PRESCALE
	} count_source_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic out;
		logic oe;
	} wave_pin_t;

endpackage

/* dual_timer.sv */
// two 8-bit timer/event counters, cascadable into one 16-bit counter
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "dual_timer_regs.svh"

module dual_timer #(
	parameter int CHANNELS = 2
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// register port
	input  wire dual_timer_pkg::reg_req_t reg_req,
	output logic [15:0]                reg_rdata,
	// event inputs from pins
	input  wire logic                  ch1_event_input,
	input  wire logic                  ch2_event_input,
	// square-wave pins
	output dual_timer_pkg::wave_pin_t  ch1_wave_output,
	output dual_timer_pkg::wave_pin_t  ch2_wave_output,
	// match interrupt requests
	output logic                       ch1_match_irq,
	output logic                       ch2_match_irq
);

	// software registers
	logic [7:0]             low_compare;
	logic [7:0]             high_compare;
	logic [7:0]             count_clock_select;
	logic [7:0]             output_control;
	logic [7:0]             timer_mode_control;

	// counters
	logic [7:0]             low_counter;
	logic [7:0]             high_counter;

	// prescaler and per-channel timing
	logic [`DIV_WIDTH-1:0]  divider;
	logic [CHANNELS-1:0]    event_raw;
	logic [CHANNELS-1:0]    ev_meta;
	logic [CHANNELS-1:0]    ev_sync;
	logic [CHANNELS-1:0]    ev_prev;
	logic [CHANNELS-1:0]    tick_raw;
	logic [CHANNELS-1:0]    wave_ff;
	logic [CHANNELS-1:0]    match;
	logic [CHANNELS-1:0]    out_en;
	logic [CHANNELS-1:0]    inv_en;

	// derived control
	logic                   cascade;
	logic                   en_low;
	logic                   en_high;
	logic                   low_step;
	logic                   high_step;
	logic                   low_hit;
	logic                   high_hit;
	logic                   full_hit;
	logic                   oc_write;

	// write strobes, one per register, and the read mux result
	logic                   wr_low_compare;
	logic                   wr_high_compare;
	logic                   wr_clock_select;
	logic                   wr_output_control;
	logic                   wr_mode_control;
	logic [15:0]            next_rdata;

	assign event_raw = {ch2_event_input, ch1_event_input};
	assign cascade   = timer_mode_control[`TMC_CASCADE_SELECT];
	assign oc_write  = wr_output_control;

	// address decode kept in one place so a new register cannot alias an old one
	always_comb begin
		wr_low_compare    = 1'b0;
		wr_high_compare   = 1'b0;
		wr_clock_select   = 1'b0;
		wr_output_control = 1'b0;
		wr_mode_control   = 1'b0;
		if (reg_req.wr) begin
			if (reg_req.addr == `ADDR_LOW_COMPARE) begin
				wr_low_compare = 1'b1;
			end else if (reg_req.addr == `ADDR_HIGH_COMPARE) begin
				wr_high_compare = 1'b1;
			end else if (reg_req.addr == `ADDR_COUNT_CLOCK_SELECT) begin
				wr_clock_select = 1'b1;
			end else if (reg_req.addr == `ADDR_OUTPUT_CONTROL) begin
				wr_output_control = 1'b1;
			end else if (reg_req.addr == `ADDR_TIMER_MODE_CONTROL) begin
				wr_mode_control = 1'b1;
			end
		end
	end

	// code to count source; prohibited codes simply never tick
	function automatic dual_timer_pkg::count_source_t decode_source(input logic [3:0] code);
		dual_timer_pkg::count_source_t src;
		src = dual_timer_pkg::SRC_NONE;
		if (code == `CODE_EDGE_RISE) begin
			src = dual_timer_pkg::SRC_EDGE_RISE;
		end else if (code == `CODE_EDGE_FALL) begin
			src = dual_timer_pkg::SRC_EDGE_FALL;
		end else if (code >= `CODE_PRESCALE_FIRST) begin
			src = dual_timer_pkg::SRC_PRESCALE;
		end
		return src;
	endfunction

	// exponent of the prescaled period: 2..10, then 12 for the top code
	function automatic logic [3:0] prescale_exp(input logic [3:0] code);
		logic [3:0] e;
		e = code - `PRESCALE_EXP_OFFSET;
		if (code == `CODE_PRESCALE_TOP) begin
			e = `PRESCALE_EXP_TOP;
		end
		return e;
	endfunction

	// free-running divider; every prescaled rate is a one-cycle tick taken from it
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			divider <= '0;
		end else begin
			divider <= divider + 1'b1;
		end
	end

	// per-channel synchroniser, edge qualifier, tick source and output flip-flop
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
			logic [3:0]                    code;
			logic [`DIV_WIDTH-1:0]         div_mask;
			dual_timer_pkg::count_source_t src;
			logic                          level_hit;
			logic                          level_low;

			assign code     = count_clock_select[gi*4 +: 4];
			assign src      = decode_source(code);
			assign div_mask = `DIV_WIDTH'((`DIV_WIDTH'(1) << prescale_exp(code)) - 1'b1);
			assign out_en[gi] = output_control[gi*`OC_STRIDE + `OC_OUTPUT_ENABLE];
			assign inv_en[gi] = output_control[gi*`OC_STRIDE + `OC_INVERT_ENABLE];

			// pins are async: two flops before anything looks at them
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					ev_meta[gi] <= 1'b0;
					ev_sync[gi] <= 1'b0;
					ev_prev[gi] <= 1'b0;
				end else begin
					ev_meta[gi] <= event_raw[gi];
					ev_sync[gi] <= ev_meta[gi];
					ev_prev[gi] <= ev_sync[gi];
				end
			end

			always_comb begin
				case (src)
					dual_timer_pkg::SRC_EDGE_RISE: tick_raw[gi] = ev_sync[gi] & ~ev_prev[gi];
					dual_timer_pkg::SRC_EDGE_FALL: tick_raw[gi] = ~ev_sync[gi] & ev_prev[gi];
					dual_timer_pkg::SRC_PRESCALE:  tick_raw[gi] = (divider & div_mask) == div_mask;
					default:                       tick_raw[gi] = 1'b0;
				endcase
			end

			// level field acts only on the write; bits above ch1 take the same layout
			assign level_hit = oc_write && (reg_req.wdata[gi*`OC_STRIDE + `OC_LEVEL_SET] ^
				reg_req.wdata[gi*`OC_STRIDE + `OC_LEVEL_RESET]);
			assign level_low = reg_req.wdata[gi*`OC_STRIDE + `OC_LEVEL_RESET];

			// flip-flop toggles only while its pin is driven and invert is on; a level write presets it either way
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					wave_ff[gi] <= 1'b0;
				end else if (level_hit) begin
					wave_ff[gi] <= ~level_low;
				end else if (match[gi] && out_en[gi] && inv_en[gi]) begin
					wave_ff[gi] <= ~wave_ff[gi];
				end
			end
		end
	endgenerate

	// enables: one gate for the pair in cascade, one per channel otherwise
	assign en_low  = timer_mode_control[`TMC_COUNT_ENABLE];
	assign en_high = cascade ? timer_mode_control[`TMC_COUNT_ENABLE] : timer_mode_control[`TMC_CH2_ENABLE];

	assign low_hit  = low_counter == low_compare;
	assign high_hit = high_counter == high_compare;
	assign full_hit = cascade && low_hit && high_hit;

	// low counter always runs from the low code, cascade or not
	assign low_step  = tick_raw[0] && en_low;
	assign high_step = cascade ? (low_step && (low_counter == `COUNT_MAX) && !full_hit)
		: (tick_raw[1] && en_high);

	assign match[0] = low_step && low_hit;
	assign match[1] = cascade ? (low_step && full_hit) : (high_step && high_hit);

	// stopped counters sit at zero so a restart always begins a full interval
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			low_counter <= `RESET_BYTE;
		end else if (!en_low) begin
			low_counter <= `RESET_BYTE;
		end else if (low_step) begin
			if (cascade) begin
				// the low byte only wraps here; the clear waits for the whole word
				low_counter <= full_hit ? `RESET_BYTE : low_counter + 1'b1;
			end else begin
				low_counter <= low_hit ? `RESET_BYTE : low_counter + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			high_counter <= `RESET_BYTE;
		end else if (!en_high) begin
			high_counter <= `RESET_BYTE;
		end else if (cascade) begin
			if (low_step && full_hit) begin
				high_counter <= `RESET_BYTE;
			end else if (high_step) begin
				high_counter <= high_counter + 1'b1;
			end
		end else if (high_step) begin
			high_counter <= high_hit ? `RESET_BYTE : high_counter + 1'b1;
		end
	end

	// interrupt requests: one-cycle pulses; masking lives in the interrupt controller
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ch1_match_irq <= 1'b0;
		end else begin
			ch1_match_irq <= match[0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ch2_match_irq <= 1'b0;
		end else begin
			ch2_match_irq <= match[1];
		end
	end

	// pins: registered level, enable released when output is off
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ch1_wave_output <= '0;
		end else begin
			ch1_wave_output.out <= wave_ff[0];
			ch1_wave_output.oe  <= out_en[0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ch2_wave_output <= '0;
		end else begin
			ch2_wave_output.out <= wave_ff[1];
			ch2_wave_output.oe  <= out_en[1];
		end
	end

	// compare registers; the 16-bit value is split by software
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			low_compare  <= `RESET_BYTE;
			high_compare <= `RESET_BYTE;
		end else begin
			if (wr_low_compare) begin
				low_compare <= reg_req.wdata[7:0];
			end
			if (wr_high_compare) begin
				high_compare <= reg_req.wdata[7:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			count_clock_select <= `RESET_BYTE;
		end else if (wr_clock_select) begin
			count_clock_select <= reg_req.wdata[7:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			timer_mode_control <= `RESET_BYTE;
		end else if (wr_mode_control) begin
			timer_mode_control <= reg_req.wdata[7:0];
		end
	end

	// level bits are never stored, so they read back zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			output_control <= `RESET_BYTE;
		end else if (oc_write) begin
			output_control <= reg_req.wdata[7:0] & ~level_field_mask();
		end
	end

	function automatic logic [7:0] level_field_mask();
		logic [7:0] m;
		m = '0;
		for (int c = 0; c < CHANNELS; c++) begin
			m[c*`OC_STRIDE + `OC_LEVEL_SET]   = 1'b1;
			m[c*`OC_STRIDE + `OC_LEVEL_RESET] = 1'b1;
		end
		return m;
	endfunction

	// read mux; the word read takes both bytes at one edge, so no torn count
	always_comb begin
		next_rdata = 16'h0000;
		if (reg_req.rd) begin
			if (reg_req.addr == `ADDR_LOW_COMPARE) begin
				next_rdata = {8'h00, low_compare};
			end else if (reg_req.addr == `ADDR_HIGH_COMPARE) begin
				next_rdata = {8'h00, high_compare};
			end else if (reg_req.addr == `ADDR_COUNT_CLOCK_SELECT) begin
				next_rdata = {8'h00, count_clock_select};
			end else if (reg_req.addr == `ADDR_OUTPUT_CONTROL) begin
				next_rdata = {8'h00, output_control};
			end else if (reg_req.addr == `ADDR_TIMER_MODE_CONTROL) begin
				next_rdata = {8'h00, timer_mode_control};
			end else if (reg_req.addr == `ADDR_COUNT_WORD) begin
				next_rdata = {high_counter, low_counter};
			end
		end
	end

	// read data stand one cycle after the strobe, then drop back to zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule

/* dual_timer_pulse_src.sv */
// external pulse source on both event pins
`timescale 1ns/100ps
module dual_timer_pulse_src (
	// clock
	input  wire logic clk_sys,
	// event pins
	output logic      ch1_event_input,
	output logic      ch2_event_input
);
	initial ch1_event_input = 1'b0;
	initial ch2_event_input = 1'b0;
	// four cycles per level so the two-flop synchroniser sees every edge
	task automatic edges(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk_sys);
			ch1_event_input <= ~ch1_event_input;
			ch2_event_input <= ~ch2_event_input;
		end
	endtask
endmodule

/* dual_timer_monitor.sv */
// port assertions of the dual timer
`timescale 1ns/100ps
module dual_timer_monitor (
	// clock and reset
	input wire logic                      clk_sys,
	input wire logic                      rst_n,
	// register port
	input wire dual_timer_pkg::reg_req_t  reg_req,
	input wire logic [15:0]               reg_rdata,
	// pins and requests
	input wire dual_timer_pkg::wave_pin_t ch1_wave_output,
	input wire dual_timer_pkg::wave_pin_t ch2_wave_output,
	input wire logic                      ch1_match_irq,
	input wire logic                      ch2_match_irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic oc_wr;
	assign oc_wr = reg_req.wr && reg_req.addr == 3'h3;
	chk_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 16'h0)
		else $error("read data not idle");
	chk_level_zero: assert property (reg_req.rd && reg_req.addr == 3'h3 |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0)
		else $error("level bits read nonzero");
	// fastest tick is four clocks, so match pulses never crowd
	chk_irq1_gap: assert property (ch1_match_irq |=> !ch1_match_irq [*3])
		else $error("ch1 request too long");
	chk_irq2_gap: assert property (ch2_match_irq |=> !ch2_match_irq [*3])
		else $error("ch2 request too long");
	chk_low_force: assert property (oc_wr && reg_req.wdata[3:2] == 2'h1 |-> ##[1:2] !ch1_wave_output.out)
		else $error("level reset ignored");
	chk_high_force: assert property (oc_wr && reg_req.wdata[3:2] == 2'h2 |-> ##[1:2] ch1_wave_output.out)
		else $error("level set ignored");
	chk_drive_on: assert property (oc_wr && reg_req.wdata[0] |-> ##[1:2] ch1_wave_output.oe)
		else $error("ch1 pin not driven");
	chk_drive_off: assert property (oc_wr && !reg_req.wdata[4] |-> ##[1:2] !ch2_wave_output.oe)
		else $error("ch2 pin still driven");
	chk_reset_quiet: assert property ($rose(rst_n) |-> !ch1_match_irq && !ch2_match_irq && !ch1_wave_output.oe)
		else $error("outputs busy after reset");
	cover property (ch1_match_irq);
	cover property (ch2_match_irq);
	cover property ($changed(ch1_wave_output.out));
endmodule
bind dual_timer dual_timer_monitor u_dual_timer_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .ch1_wave_output(ch1_wave_output), .ch2_wave_output(ch2_wave_output),
	.ch1_match_irq(ch1_match_irq), .ch2_match_irq(ch2_match_irq));

/* test_dual_timer.sv */
// self-checking bench of the dual timer
`timescale 1ns/100ps
module test_dual_timer;
	logic                      clk_sys = 1'b0;
	logic                      rst_n = 1'b0;
	dual_timer_pkg::reg_req_t  reg_req = '0;
	logic [15:0]               reg_rdata;
	logic                      ch1_event_input;
	logic                      ch2_event_input;
	dual_timer_pkg::wave_pin_t ch1_wave_output;
	dual_timer_pkg::wave_pin_t ch2_wave_output;
	logic                      ch1_match_irq;
	logic                      ch2_match_irq;
	int                        n_fail = 0;
	int                        n_checks = 0;
	int                        cyc = 0;
	int                        n1 = 0;
	int                        n2 = 0;
	int                        t2 = 0;
	int                        gap2 = 0;
	logic                      rd_d = 1'b0;
	logic [15:0]               expq[$];
	logic [31:0]               seed = 32'hfba5;
	always #50 clk_sys = ~clk_sys;
	dual_timer u_dual_timer (.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.ch1_event_input(ch1_event_input), .ch2_event_input(ch2_event_input), .ch1_wave_output(ch1_wave_output),
		.ch2_wave_output(ch2_wave_output), .ch1_match_irq(ch1_match_irq), .ch2_match_irq(ch2_match_irq));
	dual_timer_pulse_src u_dual_timer_pulse_src (.clk_sys(clk_sys), .ch1_event_input(ch1_event_input),
		.ch2_event_input(ch2_event_input));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// strobes stay up until hold or a wait clears them
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		expq.push_back(e);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
		@(posedge clk_sys);
	endtask
	task automatic hold(input int n);
		reg_req <= '0;
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic toggle(output int t);
		logic v;
		int k;
		reg_req <= '0;
		v = ch1_wave_output.out;
		k = 0;
		while (ch1_wave_output.out === v && k < 5000) begin
			@(posedge clk_sys);
			k++;
		end
		t = cyc;
		if (k == 5000) chk("toggle wait", 1, 0);
	endtask
	task automatic wait_irq2;
		int b;
		int k;
		reg_req <= '0;
		b = n2;
		k = 0;
		while (n2 == b && k < 3000) begin
			@(posedge clk_sys);
			k++;
		end
		if (k == 3000) chk("irq wait", 1, 0);
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		rd_d <= reg_req.rd;
		if (rd_d === 1'b1) chk("read data", expq.pop_front(), reg_rdata);
		if (ch1_match_irq === 1'b1) n1 <= n1 + 1;
		if (ch2_match_irq === 1'b1) begin
			n2 <= n2 + 1;
			gap2 <= cyc - t2;
			t2 <= cyc;
		end
	end
	initial begin
		#(100 * 60000);
		chk("watchdog", 0, 1);
		give_verdict();
	end
	initial begin
		int t0;
		int t1;
		int t3;
		int b1;
		int b2;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		for (int a = 0; a < 8; a++) rd(a[2:0], 16'h0);
		for (int a = 0; a < 3; a++) begin
			seed = xs(seed);
			wr(a[2:0], seed[15:0]);
			rd(a[2:0], {8'h0, seed[7:0]});
		end
		wr(3'h3, 16'h00ff);
		rd(3'h3, 16'h0033);
		wr(3'h6, 16'h00ff);
		rd(3'h6, 16'h0);
		$display("registers done");
		wr(3'h0, 16'h2);
		wr(3'h1, 16'h2);
		wr(3'h2, 16'h1);
		wr(3'h4, 16'h3);
		hold(2);
		b1 = n1;
		b2 = n2;
		u_dual_timer_pulse_src.edges(7);
		hold(8);
		chk("ch1 irqs", b1 + 1, n1);
		chk("ch2 irqs", b2 + 1, n2);
		rd(3'h5, 16'h0001);
		$display("events done");
		wr(3'h4, 16'h0);
		wr(3'h3, 16'h000b);
		hold(3);
		chk("level set", 1, ch1_wave_output.out);
		chk("drive on", 1, ch1_wave_output.oe);
		wr(3'h3, 16'h0007);
		hold(3);
		chk("level reset", 0, ch1_wave_output.out);
		wr(3'h0, 16'h0);
		for (int c = 6; c < 16; c++) begin
			wr(3'h4, 16'h0);
			wr(3'h2, c[15:0]);
			wr(3'h4, 16'h1);
			toggle(t0);
			toggle(t1);
			toggle(t3);
			chk("wave period", c == 15 ? 4096 : 1 << (c - 4), t3 - t1);
		end
		wr(3'h3, 16'h0002);
		hold(3);
		chk("drive off", 0, ch1_wave_output.oe);
		$display("wave done");
		wr(3'h4, 16'h0);
		wr(3'h2, 16'h6);
		wr(3'h0, 16'h1);
		wr(3'h1, 16'h1);
		wr(3'h4, 16'h5);
		wait_irq2();
		wait_irq2();
		b1 = n1;
		wait_irq2();
		chk("cascade period", 1032, gap2);
		chk("low matches", b1 + 2, n1);
		wr(3'h4, 16'h4);
		hold(2);
		rd(3'h5, 16'h0);
		hold(3);
		$display("cascade done");
		give_verdict();
	end
endmodule
